// ===== rtl/fcr_closed_loop_regs.sv
// closed-loop configuration register bank with apb slave and decoders
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module fcr_closed_loop_regs #(
  parameter int AW = 12                      // apb address width
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  output logic [2:0]         angle_error_ramp_code,
  output logic               overmod_on,
  output logic [4:0]         loop_accel_code,
  output logic               accel_unlimited,
  output logic [4:0]         loop_decel_code,
  output logic               decel_unlimited,
  output logic [6:0]         pwm_freq_khz,
  output logic               pwm_freq_invalid,
  output logic               estimator_smoothing_on,
  output logic [1:0]         speed_pulse_state_select,
  output logic               speed_pulse_select_undef,
  output logic [3:0]         speed_pulse_divider,
  output logic               speed_pulse_commutation,
  output logic               speed_pulse_gating,
  output logic [4:0]         speed_pulse_emf_mv,
  output logic               speed_pulse_emf_invalid,
  output logic               surge_guard_on,
  output logic [1:0]         stop_behaviour_code,
  output logic               stop_code_reserved,
  output logic [13:0]        stop_brake_ms,
  output logic [13:0]        spin_down_speed_limit,
  output logic               spin_down_invalid,
  output logic [13:0]        brake_speed_limit,
  output logic               brake_speed_invalid,
  output logic [7:0]         winding_resistance,
  output logic [7:0]         winding_inductance,
  output logic [7:0]         emf_constant,
  output logic [9:0]         current_prop_gain,
  output logic [9:0]         current_integ_gain,
  output logic               current_gains_auto,
  output logic [9:0]         velocity_prop_gain,
  output logic [9:0]         velocity_integ_gain,
  output logic [13:0]        max_speed,
  output logic [1:0]         profile_mode
);

  // index space needs address bits 9:2
  if (AW < 10) begin : g_bad_aw
    $error("fcr_closed_loop_regs: AW must be at least 10");
  end

  logic [31:0] regs_q [fcr_pkg::NUM_REGS];   // register storage
  logic [31:0] prdata_q;                     // read data captured in setup
  logic [2:0]  sel;                          // slot of current address
  logic        wr_go;                        // write accepted this edge

  // address decode, shared by write and read paths
  function automatic logic [2:0] slot_of(input logic [AW-1:0] a);
    logic [7:0] idx;
    idx = a[9:2];
    if ((a[1:0] != 2'h0) || ((a >> 10) != '0)) begin
      slot_of = fcr_pkg::SLOT_NONE;
    end else if (idx == fcr_pkg::IDX_STARTUP) begin
      slot_of = fcr_pkg::SLOT_STARTUP;
    end else if (idx == fcr_pkg::IDX_CTRL_A) begin
      slot_of = fcr_pkg::SLOT_CTRL_A;
    end else if (idx == fcr_pkg::IDX_CTRL_B) begin
      slot_of = fcr_pkg::SLOT_CTRL_B;
    end else if (idx == fcr_pkg::IDX_GAINS_A) begin
      slot_of = fcr_pkg::SLOT_GAINS_A;
    end else if (idx == fcr_pkg::IDX_GAINS_B) begin
      slot_of = fcr_pkg::SLOT_GAINS_B;
    end else if (idx == fcr_pkg::IDX_PROFILE) begin
      slot_of = fcr_pkg::SLOT_PROFILE;
    end else begin
      slot_of = fcr_pkg::SLOT_NONE;
    end
  endfunction

  // percent-of-max-speed table shared by two thresholds
  function automatic logic [6:0] pct_of(input logic [3:0] c);
    case (c)
      4'h0:    pct_of = 7'h64;
      4'h1:    pct_of = 7'h5a;
      4'h2:    pct_of = 7'h50;
      4'h3:    pct_of = 7'h46;
      4'h4:    pct_of = 7'h3c;
      4'h5:    pct_of = 7'h32;
      4'h6:    pct_of = 7'h2d;
      4'h7:    pct_of = 7'h28;
      4'h8:    pct_of = 7'h23;
      4'h9:    pct_of = 7'h1e;
      4'ha:    pct_of = 7'h19;
      4'hb:    pct_of = 7'h14;
      4'hc:    pct_of = 7'h0f;
      4'hd:    pct_of = 7'h0a;
      default: pct_of = 7'h00;             // not applicable codes
    endcase
  endfunction

  // brake hold time in milliseconds
  function automatic logic [13:0] brake_ms_of(input logic [3:0] c);
    case (c)
      4'h0:    brake_ms_of = 14'h000a;
      4'h1:    brake_ms_of = 14'h0032;
      4'h2:    brake_ms_of = 14'h0064;
      4'h3:    brake_ms_of = 14'h00c8;
      4'h4:    brake_ms_of = 14'h012c;
      4'h5:    brake_ms_of = 14'h0190;
      4'h6:    brake_ms_of = 14'h01f4;
      4'h7:    brake_ms_of = 14'h02ee;
      4'h8:    brake_ms_of = 14'h03e8;
      4'h9:    brake_ms_of = 14'h07d0;
      4'ha:    brake_ms_of = 14'h0bb8;
      4'hb:    brake_ms_of = 14'h0fa0;
      4'hc:    brake_ms_of = 14'h1388;
      4'hd:    brake_ms_of = 14'h1d4c;
      4'he:    brake_ms_of = 14'h2710;
      default: brake_ms_of = 14'h3a98;
    endcase
  endfunction

  // emf threshold magnitude in millivolts
  function automatic logic [4:0] emf_mv_of(input logic [2:0] c);
    case (c)
      3'h0:    emf_mv_of = 5'h01;
      3'h1:    emf_mv_of = 5'h02;
      3'h2:    emf_mv_of = 5'h05;
      3'h3:    emf_mv_of = 5'h0a;
      3'h4:    emf_mv_of = 5'h14;
      3'h5:    emf_mv_of = 5'h1e;
      default: emf_mv_of = 5'h00;          // not applicable
    endcase
  endfunction

  // slave never waits; errors only on unmapped or misaligned addresses
  assign sel     = slot_of(paddr);
  assign wr_go   = psel && penable && pwrite && (sel != fcr_pkg::SLOT_NONE);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && (sel == fcr_pkg::SLOT_NONE);
  assign prdata  = prdata_q;

  // one storage word per slot; masking keeps reserved and parity at zero
  for (genvar i = 0; i < fcr_pkg::NUM_REGS; i++) begin : g_reg
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        regs_q[i] <= fcr_pkg::RESET_VAL;
      end else if (wr_go && (sel == 3'(i))) begin
        regs_q[i] <= pwdata & fcr_pkg::WR_MASK[i];
      end
    end
  end

  // read data latched in setup so it stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (sel == fcr_pkg::SLOT_NONE) begin
        prdata_q <= 32'h0000_0000;         // unmapped reads zero
      end else begin
        prdata_q <= regs_q[sel];
      end
    end
  end

  // plain field views straight off the storage flops
  assign angle_error_ramp_code    = regs_q[0][fcr_pkg::RAMP_LSB +: 3];
  assign overmod_on               = regs_q[1][fcr_pkg::OVMOD_BIT];
  assign loop_accel_code          = regs_q[1][fcr_pkg::ACCEL_LSB +: 5];
  assign loop_decel_code          = regs_q[1][fcr_pkg::DECEL_LSB +: 5];
  assign estimator_smoothing_on   = regs_q[1][fcr_pkg::EST_BIT];
  assign speed_pulse_state_select = regs_q[1][fcr_pkg::FGSEL_LSB +: 2];
  assign speed_pulse_divider      = regs_q[1][fcr_pkg::FGDIV_LSB +: 4];
  assign speed_pulse_gating       = regs_q[1][fcr_pkg::FGCFG_BIT];
  assign surge_guard_on           = regs_q[1][fcr_pkg::SURGE_BIT];
  assign stop_behaviour_code      = regs_q[2][fcr_pkg::STOP_LSB +: 2];
  assign winding_resistance       = regs_q[2][fcr_pkg::RES_LSB +: 8];
  assign winding_inductance       = regs_q[2][fcr_pkg::IND_LSB +: 8];
  assign emf_constant             = regs_q[3][fcr_pkg::EMFK_LSB +: 8];
  assign current_prop_gain        = regs_q[3][fcr_pkg::CKP_LSB +: 10];
  assign current_integ_gain       = regs_q[3][fcr_pkg::CKI_LSB +: 10];
  assign velocity_integ_gain      = regs_q[4][fcr_pkg::VKI_LSB +: 10];
  assign max_speed                = regs_q[4][fcr_pkg::MAXSP_LSB +: 14];
  assign profile_mode             = regs_q[5][fcr_pkg::PROF_LSB +: 2];

  // decoded values, one cycle behind the storage flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accel_unlimited         <= 1'b0;
      decel_unlimited         <= 1'b0;
      pwm_freq_khz            <= 7'h00;
      pwm_freq_invalid        <= 1'b0;
      speed_pulse_select_undef <= 1'b0;
      speed_pulse_commutation <= 1'b0;
      speed_pulse_emf_mv      <= 5'h00;
      speed_pulse_emf_invalid <= 1'b0;
      stop_code_reserved      <= 1'b0;
      stop_brake_ms           <= 14'h0000;
      current_gains_auto      <= 1'b0;
      velocity_prop_gain      <= 10'h000;
    end else begin
      accel_unlimited  <= loop_accel_code == fcr_pkg::ACCEL_NO_LIMIT;
      decel_unlimited  <= loop_decel_code == fcr_pkg::ACCEL_NO_LIMIT;
      // invalid code reports zero rather than a bogus rate
      if (regs_q[1][fcr_pkg::PWM_LSB +: 4] == fcr_pkg::PWM_CODE_BAD) begin
        pwm_freq_khz     <= 7'h00;
        pwm_freq_invalid <= 1'b1;
      end else begin
        pwm_freq_khz     <= fcr_pkg::PWM_BASE_KHZ + fcr_pkg::PWM_STEP_KHZ
                            * {3'h0, regs_q[1][fcr_pkg::PWM_LSB +: 4]};
        pwm_freq_invalid <= 1'b0;
      end
      speed_pulse_select_undef <= speed_pulse_state_select == fcr_pkg::FGSEL_UNDEF;
      speed_pulse_commutation  <= speed_pulse_divider == fcr_pkg::FGDIV_COMMUT;
      speed_pulse_emf_mv <= emf_mv_of(regs_q[1][fcr_pkg::FGTHR_LSB +: 3]);
      speed_pulse_emf_invalid <=
        regs_q[1][fcr_pkg::FGTHR_LSB +: 3] >= fcr_pkg::EMF_FIRST_BAD;
      stop_code_reserved <= stop_behaviour_code == fcr_pkg::STOP_RESERVED;
      stop_brake_ms      <= brake_ms_of(regs_q[2][fcr_pkg::BRKT_LSB +: 4]);
      current_gains_auto <= current_prop_gain == 10'h000;
      // high three bits live in the gains_a word, low seven in gains_b
      velocity_prop_gain <= {regs_q[3][fcr_pkg::VKPHI_LSB +: 3],
                             regs_q[4][fcr_pkg::VKPLO_LSB +: 7]};
    end
  end

  // speed thresholds scaled to the max speed field; divider is a constant
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spin_down_speed_limit <= 14'h0000;
      spin_down_invalid     <= 1'b0;
      brake_speed_limit     <= 14'h0000;
      brake_speed_invalid   <= 1'b0;
    end else begin
      spin_down_speed_limit <= 14'((21'(max_speed) *
        21'(pct_of(regs_q[2][fcr_pkg::SPIN_LSB +: 4]))) / fcr_pkg::PCT_DIVISOR);
      spin_down_invalid <= regs_q[2][fcr_pkg::SPIN_LSB +: 4] >= fcr_pkg::PCT_FIRST_BAD;
      brake_speed_limit <= 14'((21'(max_speed) *
        21'(pct_of(regs_q[2][fcr_pkg::BRKSP_LSB +: 4]))) / fcr_pkg::PCT_DIVISOR);
      brake_speed_invalid <= regs_q[2][fcr_pkg::BRKSP_LSB +: 4] >= fcr_pkg::PCT_FIRST_BAD;
    end
  end

  // checks on the bank
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ramp_write;
    wr_go && (sel == fcr_pkg::SLOT_STARTUP)
      |=> angle_error_ramp_code == $past(pwdata[2:0]);
  endproperty
  a_ramp_write: assert property (p_ramp_write)
    else $error("ramp code not taken from write");

  property p_overmod;
    wr_go && (sel == fcr_pkg::SLOT_CTRL_A) |=> overmod_on == $past(pwdata[30]);
  endproperty
  a_overmod: assert property (p_overmod)
    else $error("overmod bit not stored");

  property p_accel_top;
    wr_go && (sel == fcr_pkg::SLOT_CTRL_A) && (pwdata[29:25] == 5'h1f)
      ##1 !(wr_go && (sel == fcr_pkg::SLOT_CTRL_A)) |=> accel_unlimited;
  endproperty
  a_accel_top: assert property (p_accel_top)
    else $error("top accel code not unlimited");

  property p_pwm_rate;
    wr_go && (sel == fcr_pkg::SLOT_CTRL_A) && (pwdata[18:15] == 4'h2)
      ##1 !(wr_go && (sel == fcr_pkg::SLOT_CTRL_A))
      |=> (pwm_freq_khz == 7'h14) && !pwm_freq_invalid;
  endproperty
  a_pwm_rate: assert property (p_pwm_rate)
    else $error("pwm code 2 is not 20 kHz");

  // first edge after release still shows the reset value of the flag
  property p_commut;
    $past(presetn) |-> speed_pulse_commutation == ($past(speed_pulse_divider) == 4'h0);
  endproperty
  a_commut: assert property (p_commut)
    else $error("commutation flag wrong");

  property p_brake_ms;
    $past(stop_behaviour_code) == stop_behaviour_code && $past(regs_q[2][27:24]) == 4'hf
      |-> stop_brake_ms == 14'h3a98;
  endproperty
  a_brake_ms: assert property (p_brake_ms)
    else $error("code 15 not 15 s");

  property p_auto;
    $past(presetn) && ($past(current_prop_gain) == 10'h000) |-> current_gains_auto;
  endproperty
  a_auto: assert property (p_auto)
    else $error("auto gain flag missing");

  property p_vkp;
    velocity_prop_gain == {$past(regs_q[3][2:0]), $past(regs_q[4][30:24])};
  endproperty
  a_vkp: assert property (p_vkp)
    else $error("velocity kp not assembled");

  property p_rsv_read;
    psel && penable && !pwrite && (sel == fcr_pkg::SLOT_CTRL_A)
      |-> (prdata & ~32'h7eff_fff8) == 32'h0;
  endproperty
  a_rsv_read: assert property (p_rsv_read)
    else $error("reserved bits not zero");

  property p_decel_top;
    wr_go && (sel == fcr_pkg::SLOT_CTRL_A) && (pwdata[23:19] == 5'h1f)
      ##1 !(wr_go && (sel == fcr_pkg::SLOT_CTRL_A)) |=> decel_unlimited;
  endproperty
  a_decel_top: assert property (p_decel_top)
    else $error("top decel code not unlimited");

  property p_pwm_bad;
    $past(regs_q[1][18:15]) == 4'hf |-> pwm_freq_invalid && (pwm_freq_khz == 7'h00);
  endproperty
  a_pwm_bad: assert property (p_pwm_bad)
    else $error("pwm code 15 not flagged");

  property p_emf_bad;
    $past(regs_q[1][6:4]) >= 3'h6 |-> speed_pulse_emf_invalid && (speed_pulse_emf_mv == 5'h00);
  endproperty
  a_emf_bad: assert property (p_emf_bad)
    else $error("emf code 6 or 7 not flagged");

  property p_stop_rsv;
    $past(regs_q[2][29:28]) == 2'h3 |-> stop_code_reserved;
  endproperty
  a_stop_rsv: assert property (p_stop_rsv)
    else $error("stop code 3 not flagged");

  property p_spin_bad;
    $past(regs_q[2][23:20]) >= 4'he |-> spin_down_invalid && (spin_down_speed_limit == 14'h0000);
  endproperty
  a_spin_bad: assert property (p_spin_bad)
    else $error("spin-down code e or f not flagged");

  // refused write flags an error; the out-of-range alias of ctrl_a must not land
  property p_bad_write;
    psel && penable && pwrite && (sel == fcr_pkg::SLOT_NONE)
      |-> pslverr ##1 $stable(regs_q[1]);
  endproperty
  a_bad_write: assert property (p_bad_write)
    else $error("refused write stored or not flagged");

endmodule

// ===== rtl/fcr_pkg.sv
// constants and field layout for the closed-loop configuration bank
package fcr_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_STARTUP = 8'h86;
  localparam logic [7:0] IDX_CTRL_A  = 8'h88;
  localparam logic [7:0] IDX_CTRL_B  = 8'h8a;
  localparam logic [7:0] IDX_GAINS_A = 8'h8c;
  localparam logic [7:0] IDX_GAINS_B = 8'h8e;
  localparam logic [7:0] IDX_PROFILE = 8'h94;
  // storage slots
  localparam int         NUM_REGS     = 6;
  localparam logic [2:0] SLOT_STARTUP = 3'h0;
  localparam logic [2:0] SLOT_CTRL_A  = 3'h1;
  localparam logic [2:0] SLOT_CTRL_B  = 3'h2;
  localparam logic [2:0] SLOT_GAINS_A = 3'h3;
  localparam logic [2:0] SLOT_GAINS_B = 3'h4;
  localparam logic [2:0] SLOT_PROFILE = 3'h5;
  localparam logic [2:0] SLOT_NONE    = 3'h7;
  // writable bits per slot, everything else reads zero
  localparam logic [NUM_REGS-1:0][31:0] WR_MASK = {
    32'h6000_0000, 32'h7fff_ffff, 32'h7fff_ffff,
    32'h3fff_ffff, 32'h7eff_fff8, 32'h0000_0007};
  localparam logic [31:0] RESET_VAL = 32'h0000_0000;
  // field positions
  localparam int RAMP_LSB   = 0;
  localparam int OVMOD_BIT  = 30;
  localparam int ACCEL_LSB  = 25;
  localparam int DECEL_LSB  = 19;
  localparam int PWM_LSB    = 15;
  localparam int EST_BIT    = 14;
  localparam int FGSEL_LSB  = 12;
  localparam int FGDIV_LSB  = 8;
  localparam int FGCFG_BIT  = 7;
  localparam int FGTHR_LSB  = 4;
  localparam int SURGE_BIT  = 3;
  localparam int STOP_LSB   = 28;
  localparam int BRKT_LSB   = 24;
  localparam int SPIN_LSB   = 20;
  localparam int BRKSP_LSB  = 16;
  localparam int RES_LSB    = 8;
  localparam int IND_LSB    = 0;
  localparam int EMFK_LSB   = 23;
  localparam int CKP_LSB    = 13;
  localparam int CKI_LSB    = 3;
  localparam int VKPHI_LSB  = 0;
  localparam int VKPLO_LSB  = 24;
  localparam int VKI_LSB    = 14;
  localparam int MAXSP_LSB  = 0;
  localparam int PROF_LSB   = 29;
  // code values
  localparam logic [4:0] ACCEL_NO_LIMIT = 5'h1f;
  localparam logic [3:0] PWM_CODE_BAD   = 4'hf;
  localparam logic [6:0] PWM_BASE_KHZ   = 7'h0a;
  localparam logic [6:0] PWM_STEP_KHZ   = 7'h05;
  localparam logic [1:0] FGSEL_UNDEF    = 2'h3;
  localparam logic [3:0] FGDIV_COMMUT   = 4'h0;
  localparam logic [2:0] EMF_FIRST_BAD  = 3'h6;
  localparam logic [1:0] STOP_HIZ       = 2'h0;
  localparam logic [1:0] STOP_LOW_BRAKE = 2'h1;
  localparam logic [1:0] STOP_SPIN_DOWN = 2'h2;
  localparam logic [1:0] STOP_RESERVED  = 2'h3;
  localparam logic [3:0] PCT_FIRST_BAD  = 4'he;
  localparam logic [20:0] PCT_DIVISOR   = 21'h00_0064;
endpackage

// ===== verif/fcr_closed_loop_regs_bench.sv
// self-checking bench for the closed-loop configuration register bank
`timescale 1ns/1ps
module fcr_closed_loop_regs_bench;
  logic        pclk;                   // 200 MHz bus clock
  logic        presetn;                // async reset, active low
  logic        psel, penable, pwrite;  // apb controls
  logic [11:0] paddr;                  // apb byte address
  logic [31:0] pwdata, prdata;         // apb data
  logic        pready, pslverr;        // apb answer
  logic [2:0]  angle_error_ramp_code;  // ramp code
  logic        overmod_on, accel_unlimited, decel_unlimited, pwm_freq_invalid;
  logic        estimator_smoothing_on, speed_pulse_select_undef, speed_pulse_commutation;
  logic        speed_pulse_gating, speed_pulse_emf_invalid, surge_guard_on, stop_code_reserved;
  logic        spin_down_invalid, brake_speed_invalid, current_gains_auto;
  logic [4:0]  loop_accel_code, loop_decel_code, speed_pulse_emf_mv;
  logic [6:0]  pwm_freq_khz;
  logic [1:0]  speed_pulse_state_select, stop_behaviour_code, profile_mode;
  logic [3:0]  speed_pulse_divider;
  logic [13:0] stop_brake_ms, spin_down_speed_limit, brake_speed_limit, max_speed;
  logic [7:0]  winding_resistance, winding_inductance, emf_constant;
  logic [9:0]  current_prop_gain, current_integ_gain, velocity_prop_gain, velocity_integ_gain;
  int          n_fail = 0;             // mismatches
  int          checked = 0;            // comparisons made
  logic [33:0] exp_q [$];              // notes: read flag, error, data
  logic [31:0] seed;                   // lfsr state
  logic [31:0] w [6];                  // last words written per slot
  // slot order: startup, ctrl_a, ctrl_b, gains_a, gains_b, profile
  logic [11:0] addr [6] = '{12'h218, 12'h220, 12'h228, 12'h230, 12'h238, 12'h250};
  logic [31:0] mask [6] = '{32'h0000_0007, 32'h7eff_fff8, 32'h3fff_ffff,
                            32'h7fff_ffff, 32'h7fff_ffff, 32'h6000_0000};
  // unmapped gap, misaligned, aliasing above 0x3ff, printed offset as byte address
  logic [11:0] bad [4] = '{12'h224, 12'h221, 12'h620, 12'h08c};
  int          emf_tab [8] = '{1, 2, 5, 10, 20, 30, 0, 0};
  int          ms_tab [16] = '{10, 50, 100, 200, 300, 400, 500, 750, 1000, 2000, 3000,
                               4000, 5000, 7500, 10000, 15000};
  int          pct_tab [16] = '{100, 90, 80, 70, 60, 50, 45, 40, 35, 30, 25, 20, 15, 10, 0, 0};

  fcr_closed_loop_regs #(.AW(12)) i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .angle_error_ramp_code, .overmod_on, .loop_accel_code, .accel_unlimited, .loop_decel_code,
    .decel_unlimited, .pwm_freq_khz, .pwm_freq_invalid, .estimator_smoothing_on,
    .speed_pulse_state_select, .speed_pulse_select_undef, .speed_pulse_divider,
    .speed_pulse_commutation, .speed_pulse_gating, .speed_pulse_emf_mv,
    .speed_pulse_emf_invalid, .surge_guard_on, .stop_behaviour_code, .stop_code_reserved,
    .stop_brake_ms, .spin_down_speed_limit, .spin_down_invalid, .brake_speed_limit,
    .brake_speed_invalid, .winding_resistance, .winding_inductance, .emf_constant,
    .current_prop_gain, .current_integ_gain, .current_gains_auto, .velocity_prop_gain,
    .velocity_integ_gain, .max_speed, .profile_mode
  );

  // free-running clock, 5 ns period
  always #2.5 pclk = ~pclk;

  // fibonacci-style shift register, fixed start keeps runs repeatable
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // speed limit from max speed and percent code, truncated
  function automatic logic [13:0] lim(input logic [13:0] ms, input logic [3:0] c);
    return 14'(ms * pct_tab[c] / 100);
  endfunction

  // one comparison, counted
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // apb transfer; the note is queued before the request goes out
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd,
                     input logic [31:0] rd, input logic er);
    exp_q.push_back({~wr, er, rd});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // hold everything until pready is seen; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // read every slot, expecting only writable bits back
  task automatic read_all();
    for (int k = 0; k < 6; k++) begin
      apb(1'b0, addr[k], '0, w[k] & mask[k], 1'b0);
    end
  endtask

  // compare every decoded output against the words last written
  task automatic outs(input logic [31:0] a, b, ga, gb, st, pf);
    logic [6:0] khz;
    khz = (a[18:15] == 4'hf) ? 7'h00 : 7'(10 + 5 * a[18:15]);
    chk(64'({overmod_on, loop_accel_code, accel_unlimited, loop_decel_code,
             decel_unlimited, estimator_smoothing_on, speed_pulse_state_select,
             speed_pulse_select_undef, speed_pulse_divider, speed_pulse_commutation,
             speed_pulse_gating, surge_guard_on}),
        64'({a[30], a[29:25], a[29:25] == 5'h1f, a[23:19], a[23:19] == 5'h1f, a[14],
             a[13:12], a[13:12] == 2'h3, a[11:8], a[11:8] == 4'h0, a[7], a[3]}));
    chk(64'({pwm_freq_khz, pwm_freq_invalid, speed_pulse_emf_mv, speed_pulse_emf_invalid}),
        64'({khz, a[18:15] == 4'hf, 5'(emf_tab[a[6:4]]), a[6:4] >= 3'h6}));
    chk(64'({stop_behaviour_code, stop_code_reserved, stop_brake_ms, angle_error_ramp_code,
             profile_mode, winding_resistance, winding_inductance}),
        64'({b[29:28], b[29:28] == 2'h3, 14'(ms_tab[b[27:24]]), st[2:0], pf[30:29], b[15:0]}));
    chk(64'({spin_down_speed_limit, spin_down_invalid, brake_speed_limit,
             brake_speed_invalid, max_speed}),
        64'({lim(gb[13:0], b[23:20]), b[23:20] >= 4'he, lim(gb[13:0], b[19:16]),
             b[19:16] >= 4'he, gb[13:0]}));
    chk(64'({emf_constant, current_prop_gain, current_integ_gain, current_gains_auto,
             velocity_prop_gain, velocity_integ_gain}),
        64'({ga[30:23], ga[22:13], ga[12:3], ga[22:13] == 10'h0, ga[2:0], gb[30:24],
             gb[23:14]}));
  endtask

  // monitor: every completed transfer takes the oldest note
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("ERROR t=%0t got=%h exp=%h", $time, prdata, 32'h0);
      end else begin
        chk(64'(pslverr), 64'(exp_q[0][32]));
        if (exp_q[0][33]) begin
          chk(64'(prdata), 64'(exp_q[0][31:0]));
        end
        void'(exp_q.pop_front());
      end
    end
  end

  // verdict, reached from the main sequence or the watchdog
  task automatic tally_and_finish();
    if (exp_q.size() != 0) begin
      n_fail++;
    end
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // watchdog: the full run needs about 1250 cycles
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    $display("ERROR t=%0t got=%h exp=%h", $time, 32'h1, 32'h0);
    tally_and_finish();
  end

  // main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    seed = 32'h0000_002a;
    for (int k = 0; k < 6; k++) begin
      w[k] = '0;
    end
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    read_all();
    outs(w[1], w[2], w[3], w[4], w[0], w[5]);
    $display("test reset values done");
    // sweep every code; random filler in the other bits, reserved bits included
    for (int i = 0; i < 32; i++) begin
      for (int k = 0; k < 6; k++) begin
        seed = lfsr(seed);
        w[k] = seed;
      end
      w[0][2:0] = i[2:0];
      w[1][29:25] = i[4:0];
      w[1][23:19] = ~i[4:0];
      w[1][18:15] = i[3:0];
      w[1][13:8] = {i[1:0], i[3:0]};
      w[1][6:4] = i[2:0];
      w[2][29:16] = {i[1:0], i[3:0], i[3:0], ~i[3:0]};
      w[5][30:29] = i[1:0];
      if (i == 0) begin
        w[3][22:13] = '0;
      end
      for (int k = 0; k < 6; k++) begin
        apb(1'b1, addr[k], w[k], '0, 1'b0);
      end
      read_all();
      outs(w[1], w[2], w[3], w[4], w[0], w[5]);
    end
    $display("test code sweep done");
    // refused addresses: error flagged, reads zero, nothing stored
    foreach (bad[j]) begin
      apb(1'b1, bad[j], 32'hffff_ffff, '0, 1'b1);
      apb(1'b0, bad[j], '0, '0, 1'b1);
    end
    read_all();
    $display("test refused addresses done");
    // second reset in mid-run clears everything
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      w[k] = '0;
    end
    read_all();
    outs(w[1], w[2], w[3], w[4], w[0], w[5]);
    $display("test mid-run reset done");
    repeat (2) @(posedge pclk);
    tally_and_finish();
  end
endmodule
